// [include/pwct_pkg.sv]
// constants shared by the pulse width and capture timer
`default_nettype none
package pwct_pkg;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          CNT_W       = 8;
  // register byte addresses
  localparam logic [7:0]  ADDR_CTRL_A = 8'h00;
  localparam logic [7:0]  ADDR_CTRL_B = 8'h04;
  localparam logic [7:0]  ADDR_MODE   = 8'h08;
  localparam logic [7:0]  ADDR_DATA   = 8'h0C;
  // lower_timer_control_a fields
  localparam int          CA_MODE_LSB = 0;
  localparam int          CA_CLK_LSB  = 4;
  // lower_timer_control_b fields
  localparam int          CB_RUN      = 7;
  localparam int          CB_CAPT     = 4;
  localparam int          CB_BUF      = 3;
  localparam int          CB_OVF      = 2;
  localparam int          CB_INIT     = 1;
  // composite_mode_control fields
  localparam int          MC_OUT      = 6;
  localparam int          MC_FHI      = 1;
  localparam int          MC_FLO      = 0;
  // operating mode codes
  localparam logic [3:0]  MODE_HI     = 4'h5;
  localparam logic [3:0]  MODE_LO     = 4'h6;
  localparam logic [3:0]  MODE_RR     = 4'h7;
  localparam logic [3:0]  MODE_FF     = 4'h8;
  localparam logic [3:0]  MODE_HC     = 4'h9;
  localparam logic [3:0]  MODE_CAP_R  = 4'hA;
  localparam logic [3:0]  MODE_CAP_F  = 4'hB;
  localparam logic [3:0]  MODE_CAP_B  = 4'hC;
  localparam logic [3:0]  MODE_CLR_R  = 4'hD;
  localparam logic [3:0]  MODE_CLR_F  = 4'hE;
  localparam logic [3:0]  MODE_CLR_B  = 4'hF;
  // count clock select codes
  localparam logic [2:0]  CLK_DIV1    = 3'h0;
  localparam logic [2:0]  CLK_EXT     = 3'h7;
  localparam int          PSC_W       = 6;
  // noise filter: pulses this wide are removed
  localparam int          FILT_DEPTH  = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_MAX  = 8'hFF;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN,
    ST_HIDONE
  } pwct_state_e;
endpackage : pwct_pkg
`default_nettype wire

// [include/pwct_if.sv]
// carrier between timer core and input noise filter
`default_nettype none
interface pwct_if;
  logic raw;
  logic hi_en;
  logic lo_en;
  logic filt;
  modport core (output raw, output hi_en, output lo_en, input filt);
  modport filt_side (input raw, input hi_en, input lo_en, output filt);
endinterface : pwct_if
`default_nettype wire

// [hw/pwct_filter.sv]
// input noise filter for the external event input
`default_nettype none
module pwct_filter
  import pwct_pkg::*;
(
  input  wire logic   pclk,    // machine clock
  input  wire logic   presetn, // async reset, active low
  pwct_if.filt_side   f        // synced input and filtered level
);
  logic [FILT_DEPTH-1:0] hist;
  logic                  next_filt;
  logic                  all_hi;
  logic                  all_lo;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist <= '0;
    end else begin
      hist <= {hist[FILT_DEPTH-2:0], f.raw};
    end
  end

  // a level must hold depth+1 samples before it is accepted
  assign all_hi = &{hist, f.raw};
  assign all_lo = ~|{hist, f.raw};

  always_comb begin
    next_filt = f.filt;
    if (!(f.hi_en || f.lo_en)) begin
      next_filt = f.raw;
    end else if (!f.filt) begin
      if (f.hi_en ? all_hi : hist[FILT_DEPTH-1]) begin // R15
        next_filt = 1'b1;
      end
    end else begin
      if (f.lo_en ? all_lo : !hist[FILT_DEPTH-1]) begin // R15
        next_filt = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f.filt <= 1'b0;
    end else begin
      f.filt <= next_filt; // R16
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  hi_reject_a: assert property ( // R16
    $rose(f.filt) && $past(f.hi_en) |->
      $past(f.raw, 1) && $past(f.raw, 2) && $past(f.raw, 3)
      && $past(f.raw, 4))
    else $error("filter passed a short high pulse");
endmodule : pwct_filter
`default_nettype wire

// [hw/pwct_top.sv]
// pulse width measurement and input capture timer, APB slave
// Summary of operation
// (R1) start edge clears counter, counting begins
// (R2) end edge stores count, sets both flags
// (R3) data register read clears buffer-full
// (R4) buffer-full blocks data overwrite, result dropped
// (R5) mode 1001 keeps high result, drops cycle
// (R6) software reads high result before cycle ends
// (R7) counter wrap sets overflow flag
// (R8) overflow inverts output, start from initial bit
// (R9) stopped timer holds output level
// (R10) mode field selects start, end, capture edges
// (R11) capture stores counter on selected edge
// (R12) clear capture stores, flags, zeroes counter
// (R13) free-run capture stores, counter keeps running
// (R14) capture leaves buffer-full untouched
// (R15) filter bits suppress high, low or both
// (R16) filter drops three-cycle pulses, four-cycle delay
// (R17) mode codes 0101..1111 decode as listed
// (R18) external clock code forced to 000
// (R19) run enable zero stops, clears count
// (R20) event input synchronised before filter, edges
// (R21) flags cleared by writing zero only
`default_nettype none
module pwct_top
  import pwct_pkg::*;
(
  input  wire logic              pclk,     // machine clock
  input  wire logic              presetn,  // async reset, active low
  input  wire logic              psel,     // apb select
  input  wire logic              penable,  // apb access phase
  input  wire logic              pwrite,   // apb write
  input  wire logic [ADDR_W-1:0] paddr,    // apb byte address
  input  wire logic [DATA_W-1:0] pwdata,   // apb write data
  output logic      [DATA_W-1:0] prdata,   // apb read data
  output logic                   pready,   // apb ready
  output logic                   pslverr,  // apb error, unmapped
  input  wire logic   external_event_input, // measured pulse pin
  output logic                   timer_out // timer output pin
);
  pwct_if fi ();

  logic [3:0]       mode;
  logic [2:0]       clk_sel;
  logic             run_enable;
  logic             init_level;
  logic             filter_sel_lower_hi;
  logic             filter_sel_lower_lo;
  logic             capture_flag;
  logic             buffer_full_flag;
  logic             overflow_flag;
  logic [CNT_W-1:0] lower_timer_data;
  logic [CNT_W-1:0] cnt;
  logic [PSC_W-1:0] psc;
  logic             lower_output_level;
  logic             sync1;
  logic             sync2;
  logic             filt_prev;
  logic             rise;
  logic             fall;
  logic             tick;
  logic             wr;
  logic             rd_data;
  logic             mapped;
  logic             run_start;
  logic             store;
  logic             clr;
  logic             ovf;
  logic             counting;
  logic [DATA_W-1:0] rd_word;
  logic [PSC_W-1:0]  psc_mask;
  logic [2:0]        w_clk;
  logic [3:0]        w_mode;
  pwct_state_e       state;
  pwct_state_e       next_state;

  // mode decode
  function automatic logic is_meas(input logic [3:0] m);
    is_meas = (m >= MODE_HI) && (m <= MODE_HC); // R17
  endfunction : is_meas

  function automatic logic is_cap(input logic [3:0] m);
    is_cap = (m >= MODE_CAP_R); // R17
  endfunction : is_cap

  function automatic logic start_edge(input logic [3:0] m,
                                      input logic r,
                                      input logic f);
    case (m)
      MODE_LO, MODE_FF: start_edge = f;
      default:          start_edge = r;
    endcase
  endfunction : start_edge

  function automatic logic end_edge(input logic [3:0] m,
                                    input logic r,
                                    input logic f);
    case (m)
      MODE_HI, MODE_FF, MODE_CAP_F, MODE_CLR_F: end_edge = f;
      MODE_CAP_B, MODE_CLR_B:                   end_edge = r || f;
      default:                                  end_edge = r;
    endcase
  endfunction : end_edge

  // apb slave, zero wait states
  assign wr      = psel && penable && pwrite;
  assign rd_data = psel && penable && !pwrite && (paddr == ADDR_DATA);
  assign mapped  = (paddr == ADDR_CTRL_A) || (paddr == ADDR_CTRL_B) ||
                   (paddr == ADDR_MODE) || (paddr == ADDR_DATA);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    rd_word = '0;
    case (paddr)
      ADDR_CTRL_A: begin
        rd_word[CA_CLK_LSB +: 3]  = clk_sel;
        rd_word[CA_MODE_LSB +: 4] = mode;
      end
      ADDR_CTRL_B: begin
        rd_word[CB_RUN]  = run_enable;
        rd_word[CB_CAPT] = capture_flag;
        rd_word[CB_BUF]  = buffer_full_flag;
        rd_word[CB_OVF]  = overflow_flag;
        rd_word[CB_INIT] = init_level;
      end
      ADDR_MODE: begin
        rd_word[MC_OUT] = lower_output_level;
        rd_word[MC_FHI] = filter_sel_lower_hi;
        rd_word[MC_FLO] = filter_sel_lower_lo;
      end
      ADDR_DATA: rd_word[CNT_W-1:0] = lower_timer_data;
      default:   rd_word = '0;
    endcase
  end

  // read data is latched in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_word;
    end
  end

  // mode and clock are frozen while running
  assign w_mode = pwdata[CA_MODE_LSB +: 4];
  assign w_clk  = pwdata[CA_CLK_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode    <= '0;
      clk_sel <= '0;
    end else if (wr && paddr == ADDR_CTRL_A && !run_enable) begin
      mode <= w_mode;
      if (w_clk == CLK_EXT && (is_meas(w_mode) || is_cap(w_mode))) begin
        clk_sel <= CLK_DIV1; // R18
      end else begin
        clk_sel <= w_clk;
      end
    end
  end

  assign run_start = wr && paddr == ADDR_CTRL_B && pwdata[CB_RUN] &&
                     !run_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_enable          <= 1'b0;
      init_level          <= 1'b0;
      filter_sel_lower_hi <= 1'b0;
      filter_sel_lower_lo <= 1'b0;
    end else if (wr && paddr == ADDR_CTRL_B) begin
      run_enable <= pwdata[CB_RUN];
      init_level <= pwdata[CB_INIT];
    end else if (wr && paddr == ADDR_MODE) begin
      filter_sel_lower_hi <= pwdata[MC_FHI];
      filter_sel_lower_lo <= pwdata[MC_FLO];
    end
  end

  // two-stage synchroniser on the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= external_event_input; // R20
      sync2 <= sync1;
    end
  end

  assign fi.raw   = sync2;
  assign fi.hi_en = filter_sel_lower_hi;
  assign fi.lo_en = filter_sel_lower_lo;

  pwct_filter u_filter (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (fi.filt_side)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_prev <= 1'b0;
    end else begin
      filt_prev <= fi.filt;
    end
  end

  assign rise = fi.filt && !filt_prev; // R20
  assign fall = !fi.filt && filt_prev;

  // prescaler; the external clock code gives no ticks here
  assign psc_mask = PSC_W'((7'h01 << clk_sel) - 7'h01);
  assign tick     = ((psc & psc_mask) == '0) && (clk_sel != CLK_EXT);
  assign counting = (state == ST_RUN) || (state == ST_HIDONE);
  // a stop write leaves one stale RUN cycle; keep it from toggling
  assign ovf      = counting && tick && !clr && run_enable &&
                    (cnt == CNT_MAX);

  // measurement and capture sequencing
  always_comb begin
    next_state = state;
    store      = 1'b0;
    clr        = 1'b0;
    case (state)
      ST_IDLE: begin
        if (run_enable) begin
          next_state = is_cap(mode) ? ST_RUN : ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start_edge(mode, rise, fall)) begin // R10
          clr        = 1'b1; // R1
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (is_cap(mode)) begin
          if (end_edge(mode, rise, fall)) begin // R10
            store = 1'b1; // R11
            clr   = (mode >= MODE_CLR_R); // R12 R13
          end
        end else if (mode == MODE_HC) begin
          if (fall) begin
            store      = 1'b1; // R5
            next_state = ST_HIDONE;
          end
        end else if (end_edge(mode, rise, fall)) begin
          store = !buffer_full_flag; // R4
          if (mode == MODE_RR || mode == MODE_FF) begin
            clr = 1'b1;
          end else begin
            next_state = ST_ARMED;
          end
        end
      end
      ST_HIDONE: begin
        if (rise) begin
          // cycle result survives only if the high result was read
          store      = !buffer_full_flag; // R5 R6
          clr        = 1'b1;
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!run_enable) begin
      next_state = ST_IDLE;
      store      = 1'b0;
      clr        = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cnt   <= CNT_ZERO;
      psc   <= '0;
    end else begin
      state <= next_state;
      if (!run_enable || clr) begin
        cnt <= CNT_ZERO; // R19 R1 R12
        psc <= '0;
      end else begin
        psc <= psc + PSC_W'(1);
        if (counting && tick) begin
          cnt <= cnt + CNT_W'(1); // R13
        end
      end
    end
  end

  // data register and flags; hardware set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_timer_data <= CNT_ZERO;
    end else if (store) begin
      lower_timer_data <= cnt; // R2 R11
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (store) begin
        capture_flag <= 1'b1; // R2 R12 R13
      end else if (wr && paddr == ADDR_CTRL_B && !pwdata[CB_CAPT]) begin
        capture_flag <= 1'b0; // R21
      end
      if (ovf) begin
        overflow_flag <= 1'b1; // R7
      end else if (wr && paddr == ADDR_CTRL_B && !pwdata[CB_OVF]) begin
        overflow_flag <= 1'b0; // R21
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buffer_full_flag <= 1'b0;
    end else if (store && is_meas(mode)) begin
      buffer_full_flag <= 1'b1; // R2 R14
    end else if (rd_data) begin
      buffer_full_flag <= 1'b0; // R3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_output_level <= 1'b0;
    end else if (run_start) begin
      lower_output_level <= pwdata[CB_INIT]; // R8
    end else if (ovf) begin
      lower_output_level <= !lower_output_level; // R8 R9
    end
  end

  assign timer_out = lower_output_level;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  stop_clear_a: assert property (!run_enable |=> cnt == CNT_ZERO) // R19
    else $error("count not zero while stopped");
  start_zero_a: assert property ( // R1
    state == ST_ARMED && start_edge(mode, rise, fall) && run_enable
    |=> cnt == CNT_ZERO && state == ST_RUN)
    else $error("start edge did not clear counter");
  store_copy_a: assert property ( // R2
    store && is_meas(mode) |=> lower_timer_data == $past(cnt)
    && buffer_full_flag && capture_flag)
    else $error("measurement not stored with flags");
  bf_read_a: assert property ( // R3
    rd_data && !store |=> !buffer_full_flag)
    else $error("data read left buffer full set");
  bf_hold_a: assert property ( // R4
    buffer_full_flag && is_meas(mode) && !(state == ST_RUN
    && mode == MODE_HC) |=> $stable(lower_timer_data))
    else $error("data overwritten while buffer full");
  ovf_flag_a: assert property ( // R7
    counting && tick && cnt == CNT_MAX && run_enable && !clr
    |=> overflow_flag ##0 cnt == CNT_ZERO)
    else $error("wrap did not set overflow flag");
  out_toggle_a: assert property ( // R8
    ovf && !run_start |=> timer_out != $past(timer_out))
    else $error("overflow did not invert output");
  out_hold_a: assert property ( // R9
    !run_enable && !run_start |=> $stable(timer_out))
    else $error("stopped timer changed output");
  cap_bf_a: assert property ( // R14
    is_cap(mode) && !buffer_full_flag |=> !buffer_full_flag)
    else $error("capture touched buffer full");
  no_ext_clk_a: assert property ( // R18
    is_meas(mode) || is_cap(mode) |-> clk_sel != CLK_EXT)
    else $error("external clock kept in measure mode");
endmodule : pwct_top
`default_nettype wire

// [tb/pwct_src.sv]
// pulse source model that drives the timer event input pin
`default_nettype none
module pwct_src (
  input  wire logic pclk, // machine clock
  output logic      pin   // event input drive
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin = 1'b0;

  // changes only just after an edge, so every width is whole cycles
  task automatic lvl(input logic v, input int n);
    pin <= v;
    repeat (n) @(posedge pclk);
  endtask : lvl

  // low gap, high h1, low l, high h2, then back to low
  task automatic pat(input int h1, input int l, input int h2);
    lvl(1'b0, 10);
    lvl(1'b1, h1);
    lvl(1'b0, l);
    lvl(1'b1, h2);
    lvl(1'b0, 20);
  endtask : pat

  // n toggles, half cycles apart, first one rising
  task automatic square(input int half, input int n);
    for (int i = 0; i < n; i++) begin
      lvl(~pin, half);
    end
  endtask : square
endmodule : pwct_src
`default_nettype wire

// [tb/tb_pulse_width_and_capture_timer.sv]
// self-checking bench for the pulse width and capture timer
`default_nettype none
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) begin \
      fails++; \
      $display("mismatch at %0t: got %h exp %h", $time, a, b); \
    end \
  end
module tb_pulse_width_and_capture_timer;
  import pwct_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, q;
  logic              pready, pslverr, ev, tout, e;
  logic [7:0]        dm, dc;
  logic [7:0]        r[$];
  int                fails = 0, check_count = 0, cyc = 0;
  int                k, h1, l, h2, x, n, p, pp, t0;

  pwct_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_event_input(ev), .timer_out(tout));
  pwct_src src (.pclk(pclk), .pin(ev));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // whole run needs about 6000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      final_report();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // stop, drain the data register so buffer-full cannot block, restart
  task automatic start(input logic [3:0] m, input logic [31:0] ctl);
    wr(ADDR_CTRL_B, 32'h0);
    rd(ADDR_DATA);
    wr(ADDR_CTRL_A, {28'h0, m});
    wr(ADDR_CTRL_B, ctl);
  endtask : start

  task automatic meas(input logic [3:0] m, input int mid);
    start(m, 32'h80);
    fork
      src.pat(h1, l, h2);
      if (mid > 0) begin
        repeat (mid) @(posedge pclk);
        rd(ADDR_DATA);
        dm = q[7:0];
        repeat (l) @(posedge pclk);
        rd(ADDR_DATA);
        dc = q[7:0];
      end
    join
    rd(ADDR_CTRL_B);
    `CHK(q[4:3], 2'b11)
    rd(ADDR_DATA);
    x = int'(q[7:0]);
    rd(ADDR_CTRL_B);
    `CHK(q[3], 1'b0)
  endtask : meas

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    void'($urandom(32'hB372BCB8));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      `CHK(q, 32'h0)
    end
    rd(8'h10);
    `CHK({e, q}, 33'h1_0000_0000)
    `CHK(pready, 1'b1)
    wr(ADDR_CTRL_A, 32'h75);
    rd(ADDR_CTRL_A);
    `CHK(q, 32'h05)
    // first high-pulse run calibrates the fixed edge latency k
    for (int m = 5; m <= 9; m++) begin
      h1 = 8 + $urandom % 40;
      l  = 30 + $urandom % 30;
      h2 = 24 + $urandom % 30;
      meas(4'(m), 0);
      case (m)
        5: k = x - h1;
        6: `CHK(8'(x), 8'(l + k))
        7: `CHK(8'(x), 8'(h1 + l + k))
        8: `CHK(8'(x), 8'(l + h2 + k))
        default: `CHK(8'(x), 8'(h2 + k))
      endcase
    end
    meas(MODE_HC, 22 + h1);
    `CHK(dm, 8'(h1 + k))
    `CHK(dc, 8'(h1 + l + k))
    `CHK(8'(x), 8'(h2 + k))
    for (int m = 10; m <= 15; m++) begin
      start(4'(m), 32'h80);
      t0 = cyc;
      r = {};
      fork
        src.square(40, 6);
        for (int i = 0; i < 6; i++) begin
          wait (cyc >= t0 + 30 + 40 * i);
          rd(ADDR_DATA);
          r.push_back(q[7:0]);
        end
      join
      rd(ADDR_CTRL_B);
      `CHK(q[4:3], 2'b10)
      p  = -1;
      pp = -1;
      for (int i = 0; i < 6; i++) begin
        if ((m % 3 == 1 && i % 2 == 0) || (m % 3 == 2 && i % 2 == 1)
            || m % 3 == 0) begin
          if (m < 13 && p >= 0)
            `CHK(r[i], 8'(r[p] + 40 * (i - p)))
          if (m >= 13 && pp >= 0)
            `CHK(r[i], r[p])
          pp = p;
          p  = i;
        end else if (i > 0)
          `CHK(r[i], r[i-1])
      end
    end
    for (int dv = 0; dv < 2; dv++) begin
      start({dv[0], MODE_CAP_R[2:0]} | 4'h8, 32'h0);
      wr(ADDR_CTRL_A, {25'h0, 3'(dv), MODE_CAP_R});
      wr(ADDR_CTRL_B, 32'h82);
      @(posedge pclk);
      `CHK(tout, 1'b1)
      n = 0;
      while (tout === 1'b1 && n < 1200) begin
        @(posedge pclk);
        n++;
      end
      n = 0;
      while (tout === 1'b0 && n < 1200) begin
        @(posedge pclk);
        n++;
      end
      `CHK(n, 256 << dv)
      rd(ADDR_MODE);
      `CHK(q[6], 1'b1)
      rd(ADDR_CTRL_B);
      `CHK(q[2], 1'b1)
      wr(ADDR_CTRL_B, 32'h84);
      rd(ADDR_CTRL_B);
      `CHK(q[2], 1'b1)
      wr(ADDR_CTRL_B, 32'h80);
      rd(ADDR_CTRL_B);
      `CHK(q[2], 1'b0)
      wr(ADDR_CTRL_B, 32'h0);
      repeat (600) @(posedge pclk);
      `CHK(tout, 1'b1)
    end
    // last, since the low-pulse pass leaves the pin high
    for (p = 1; p >= 0; p--) begin
      wr(ADDR_MODE, p ? 32'h2 : 32'h1);
      start(p ? MODE_HI : MODE_LO, 32'h80);
      src.lvl(~p[0], 10);
      src.lvl(p[0], 3);
      src.lvl(~p[0], 20);
      rd(ADDR_CTRL_B);
      `CHK(q[4], 1'b0)
      h1 = 5 + $urandom % 20;
      src.lvl(p[0], h1);
      src.lvl(~p[0], 20);
      rd(ADDR_DATA);
      `CHK(q[7:0], 8'(h1 + k))
    end
    final_report();
  end
endmodule : tb_pulse_width_and_capture_timer
`undef CHK
`default_nettype wire
